// ---- rtl/tfd_divider.sv ----
// module: channel 0 frequency divider with register port and interrupt
//
// Functional notes
// - divider exists only on channel 0: input pin in, output pin out.
// - single edge: output = input / (2 x (reload + 1)).
// - both edges: output is about input / (reload + 1).
// - counter counts down by one per valid input edge.
// - after start trigger, load reload value at next valid edge.
// - first load raises irq and toggles output only if start select is 1.
// - at zero: toggle output, reload, keep counting.
// - edges sampled on operation clock; one clock period jitter.
// - reload rewrite takes effect only at the following reload.
// - count value read only, reads FFFFH after reset.
// - mode register resets to 0000H.
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module tfd_divider
#(
    parameter int CNT_W = 16
)
(
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    // register port
    input  wire logic [tfd_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]                reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [31:0]                reg_rdata,
    // pins
    input  wire logic                       divider_input_pin,
    output logic                            divider_output_pin,
    // interrupt
    output logic                            channel_irq
);
    // ------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------
    if (CNT_W != 16)
    begin : g_bad_width
        $error("CNT_W must be 16");
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_ARM  = 3'b010,
        ST_RUN  = 3'b100
    } tfd_state_t;

    tfd_state_t  state_r;
    logic [15:0] channel_mode_reg;
    logic [15:0] reload_value_reg;
    logic [15:0] down_count_value;
    logic        out_r;
    logic        stat_r;
    logic        en_r;
    logic        irq_r;
    logic [31:0] rdata_r;
    logic        tick;
    logic        arm_load;
    logic        zero_hit;
    logic        start_wr;
    logic        clr_wr;

    tfd_edge_if eb ();

    tfd_edge_det u_edge
    (
        .core_clk          (core_clk),
        .rst               (rst),
        .divider_input_pin (divider_input_pin),
        .eb                (eb)
    );

    assign eb.edge_sel = channel_mode_reg[tfd_pkg::MODE_EDGE_LSB +:
                                          tfd_pkg::MODE_EDGE_W];

    assign start_wr = reg_wr & (reg_addr == tfd_pkg::ADR_START)
                      & reg_wdata[0];
    assign clr_wr   = reg_wr & (reg_addr == tfd_pkg::ADR_CLEAR)
                      & reg_wdata[tfd_pkg::STAT_TICK_BIT];

    // ------------------------------------------------------------------
    // control state machine
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
            state_r <= ST_IDLE;
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (start_wr)
                        state_r <= ST_ARM;
                end
                ST_ARM:
                begin
                    if (eb.valid_edge)
                        state_r <= ST_RUN;
                end
                ST_RUN:
                begin
                    if (start_wr)
                        state_r <= ST_ARM;
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    assign arm_load = (state_r == ST_ARM) & eb.valid_edge;
    assign zero_hit = (state_r == ST_RUN) & eb.valid_edge
                      & (down_count_value == tfd_pkg::ZERO_CNT);
    // first-load event counts only when start select is set
    assign tick = zero_hit | (arm_load &
                  channel_mode_reg[tfd_pkg::MODE_START_IRQ_BIT]);

    // ------------------------------------------------------------------
    // registers written by software
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
            channel_mode_reg <= tfd_pkg::MODE_RST;
        else if (reg_wr && reg_addr == tfd_pkg::ADR_MODE)
            channel_mode_reg <= reg_wdata[15:0];
    end

    // software may rewrite at any time; only sampled at load time
    always_ff @(posedge core_clk)
    begin
        if (rst)
            reload_value_reg <= tfd_pkg::RELOAD_RST;
        else if (reg_wr && reg_addr == tfd_pkg::ADR_RELOAD)
            reload_value_reg <= reg_wdata[15:0];
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            en_r <= 1'b0;
        else if (reg_wr && reg_addr == tfd_pkg::ADR_ENABLE)
            en_r <= reg_wdata[tfd_pkg::STAT_TICK_BIT];
    end

    // ------------------------------------------------------------------
    // down counter
    // ------------------------------------------------------------------
    // a period is reload+1 edges: load, count down to zero, reload on the
    // edge that finds the count at zero, so zero is held for one edge
    always_ff @(posedge core_clk)
    begin
        if (rst)
            down_count_value <= tfd_pkg::COUNT_RST;
        else if (arm_load)
            down_count_value <= reload_value_reg;
        else if (state_r == ST_RUN && eb.valid_edge)
        begin
            if (down_count_value == tfd_pkg::ZERO_CNT)
                down_count_value <= reload_value_reg;
            else
                down_count_value <= down_count_value - 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // divider output
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
            out_r <= 1'b0;
        else if (state_r == ST_RUN && eb.valid_edge
                 && down_count_value == tfd_pkg::ZERO_CNT)
            out_r <= ~out_r;
        else if (arm_load
                 && channel_mode_reg[tfd_pkg::MODE_START_IRQ_BIT])
            out_r <= ~out_r;
        // otherwise held, including before start
        else
            out_r <= out_r;
    end

    assign divider_output_pin = out_r;

    // ------------------------------------------------------------------
    // interrupt status, set wins over clear
    // ------------------------------------------------------------------
    logic out_tick;
    assign out_tick = (state_r == ST_RUN) & eb.valid_edge
                      & (down_count_value == tfd_pkg::ZERO_CNT);

    always_ff @(posedge core_clk)
    begin
        if (rst)
            stat_r <= 1'b0;
        else if (out_tick ||
                 (arm_load && channel_mode_reg[tfd_pkg::MODE_START_IRQ_BIT]))
            stat_r <= 1'b1;
        else if (clr_wr)
            stat_r <= 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            irq_r <= 1'b0;
        else
            irq_r <= (stat_r & en_r) | ((out_tick | tick) & en_r);
    end

    assign channel_irq = irq_r;

    // ------------------------------------------------------------------
    // read data, one cycle after the strobe, zero otherwise
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
            rdata_r <= 32'h0000_0000;
        else if (!reg_rd)
            rdata_r <= 32'h0000_0000;
        else if (reg_addr == tfd_pkg::ADR_MODE)
            rdata_r <= {16'h0000, channel_mode_reg};
        else if (reg_addr == tfd_pkg::ADR_RELOAD)
            rdata_r <= {16'h0000, reload_value_reg};
        else if (reg_addr == tfd_pkg::ADR_COUNT)
            rdata_r <= {16'h0000, down_count_value};
        else if (reg_addr == tfd_pkg::ADR_STATUS)
            rdata_r <= {31'h0000_0000, stat_r};
        else if (reg_addr == tfd_pkg::ADR_ENABLE)
            rdata_r <= {31'h0000_0000, en_r};
        else
            rdata_r <= 32'h0000_0000;
    end

    assign reg_rdata = rdata_r;
endmodule : tfd_divider
`default_nettype wire

// ---- rtl/tfd_pkg.sv ----
// package: register map, field layout and reset values of the frequency divider
package tfd_pkg;
    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam int         ADDR_W      = 5;
    localparam logic [4:0] ADR_MODE    = 5'h00;
    localparam logic [4:0] ADR_RELOAD  = 5'h04;
    localparam logic [4:0] ADR_COUNT   = 5'h08;
    localparam logic [4:0] ADR_START   = 5'h0C;
    localparam logic [4:0] ADR_STATUS  = 5'h10;
    localparam logic [4:0] ADR_CLEAR   = 5'h14;
    localparam logic [4:0] ADR_ENABLE  = 5'h18;
    // ------------------------------------------------------------------
    // mode register fields
    // ------------------------------------------------------------------
    localparam int MODE_START_IRQ_BIT = 0;
    localparam int MODE_EDGE_LSB      = 6;
    localparam int MODE_EDGE_W        = 2;
    localparam logic [1:0] EDGE_FALL  = 2'h0;
    localparam logic [1:0] EDGE_RISE  = 2'h1;
    localparam logic [1:0] EDGE_BOTH  = 2'h2;
    // status bits
    localparam int STAT_TICK_BIT = 0;
    localparam int STAT_W        = 1;
    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] MODE_RST   = 16'h0000;
    localparam logic [15:0] COUNT_RST  = 16'hFFFF;
    localparam logic [15:0] RELOAD_RST = 16'h0000;
    localparam logic [15:0] ZERO_CNT   = 16'h0000;
endpackage : tfd_pkg

// ---- rtl/tfd_edge_if.sv ----
// interface: edge detector to counter core
`timescale 1ns/1ps
`default_nettype none
interface tfd_edge_if;
    logic       valid_edge;
    logic [1:0] edge_sel;
    modport det  (output valid_edge, input edge_sel);
    modport core (input valid_edge, output edge_sel);
endinterface : tfd_edge_if
`default_nettype wire

// ---- rtl/tfd_edge_det.sv ----
// module: samples the divider input and flags selected edges
`timescale 1ns/1ps
`default_nettype none
module tfd_edge_det
(
    // clock and reset
    input  wire logic  core_clk,
    input  wire logic  rst,
    // pin
    input  wire logic  divider_input_pin,
    // to core
    tfd_edge_if.det    eb
);
    logic prev_r;
    logic edge_r;
    logic rise;
    logic fall;

    assign rise = divider_input_pin & ~prev_r;
    assign fall = ~divider_input_pin & prev_r;

    // pin sampled on the operation clock; one-clock period jitter
    always_ff @(posedge core_clk)
    begin
        if (rst)
            prev_r <= 1'b0;
        else
            prev_r <= divider_input_pin;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            edge_r <= 1'b0;
        else if (eb.edge_sel == tfd_pkg::EDGE_BOTH)
            edge_r <= rise | fall;
        else if (eb.edge_sel == tfd_pkg::EDGE_RISE)
            edge_r <= rise;
        else
            edge_r <= fall;
    end

    assign eb.valid_edge = edge_r;
endmodule : tfd_edge_det
`default_nettype wire

// ---- testbench/tfd_divider_asserts.sv ----
// checker: port-level assertions of the frequency divider
`timescale 1ns/1ps
`default_nettype none
module tfd_divider_asserts
#(
    parameter int CNT_W = 16
)
(
    // clock and reset
    input wire logic                       core_clk,
    input wire logic                       rst,
    // register port
    input wire logic [tfd_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0]                reg_wdata,
    input wire logic                       reg_wr,
    input wire logic                       reg_rd,
    input wire logic [31:0]                reg_rdata,
    // pins and interrupt
    input wire logic                       divider_input_pin,
    input wire logic                       divider_output_pin,
    input wire logic                       channel_irq
);
    // ----
    // properties
    // ----
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside answer cycle");
    a_upper_zero: assert property ($past(reg_rd) |-> reg_rdata[31:CNT_W] == 0)
        else $error("upper read bits set");
    a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) == 5'h1C
        |-> reg_rdata == 32'h0) else $error("unmapped read not zero");
    a_status_bits: assert property ($past(reg_rd) && $past(reg_addr) ==
        tfd_pkg::ADR_STATUS |-> reg_rdata[31:1] == 0) else $error("status bits");
    a_out_cause: assert property ($changed(divider_output_pin) |->
        $past(divider_input_pin, 1) != $past(divider_input_pin, 6))
        else $error("output toggled without input edge");
    a_out_reset: assert property ($past(rst) |-> !divider_output_pin)
        else $error("output not low after reset");
    a_irq_clear: assert property (reg_wr && reg_addr == tfd_pkg::ADR_CLEAR
        && reg_wdata[0] && $past(divider_input_pin, 6) == divider_input_pin
        ##1 $stable(divider_input_pin) |-> ##2 !channel_irq)
        else $error("irq not cleared");
    a_irq_masked: assert property (reg_wr && reg_addr == tfd_pkg::ADR_ENABLE
        && !reg_wdata[0] |=> ##2 !channel_irq [*2]) else $error("irq not masked");
endmodule : tfd_divider_asserts
bind tfd_divider tfd_divider_asserts #(.CNT_W(CNT_W)) chk_u (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .divider_input_pin(divider_input_pin),
    .divider_output_pin(divider_output_pin), .channel_irq(channel_irq));
`default_nettype wire

// ---- testbench/tfd_clk_src.sv ----
// model: external clock source on the divider input pin
`timescale 1ns/1ps
`default_nettype none
module tfd_clk_src
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // control
    input  wire logic       run,
    input  wire logic [3:0] half,
    // pin
    output logic            pin
);
    logic [3:0] cnt_r;
    // ----
    // pin stands still while run is low
    // ----
    always_ff @(posedge core_clk)
    begin
        if (rst || !run || cnt_r == half - 4'h1)
            cnt_r <= 4'h0;
        else
            cnt_r <= cnt_r + 4'h1;
    end
    always_ff @(posedge core_clk)
    begin
        if (rst)
            pin <= 1'b0;
        else if (run && cnt_r == half - 4'h1)
            pin <= ~pin;
    end
endmodule : tfd_clk_src
`default_nettype wire

// ---- testbench/tfd_divider_tb.sv ----
// testbench: random and corner-case runs of the frequency divider
`timescale 1ns/1ps
`default_nettype none
module tfd_divider_tb;
    logic        core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [4:0]  reg_addr = 5'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_v;
    logic [31:0] seed = 32'h04E97E46;
    logic        pin, pin_d = 1'b0, dout, dout_d = 1'b0, irq, sel;
    logic        run = 1'b0, cnt_on = 1'b0;
    logic [3:0]  half = 4'h6;
    logic [1:0]  esel = 2'h0;
    int          fail_count = 0, cmp_count = 0, edges = 0, tog = 0, r;
    int          e1, t1;
    // ----
    // design, source and observers
    // ----
    tfd_divider dut_u (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .divider_input_pin(pin),
        .divider_output_pin(dout), .channel_irq(irq));
    tfd_clk_src src_u (.core_clk(core_clk), .rst(rst), .run(run),
        .half(half), .pin(pin));
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        pin_d <= pin;
        dout_d <= dout;
        edges <= !cnt_on ? 0 : edges + int'(pin !== pin_d &&
            (esel == tfd_pkg::EDGE_BOTH || pin === (esel == tfd_pkg::EDGE_RISE)));
        tog <= !cnt_on ? 0 : tog + int'(dout !== dout_d);
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic int exp_tog(input int e, input int rv, input int s);
        return e == 0 ? 0 : s + (e - 1) / (rv + 1);
    endfunction : exp_tog
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    task automatic rd(input logic [4:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        rd_v = reg_rdata;
        @(posedge core_clk);
    endtask : rd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    initial
    begin
        #200000;
        fail_count++;
        end_of_test();
    end
    initial
    begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd(tfd_pkg::ADR_MODE);
        chk(rd_v, 32'h0);
        wr(tfd_pkg::ADR_COUNT, 32'h1234);
        rd(tfd_pkg::ADR_COUNT);
        chk(rd_v, 32'hFFFF);
        rd(5'h1C);
        chk(rd_v, 32'h0);
        run <= 1'b1;
        repeat (40) @(posedge core_clk);
        run <= 1'b0;
        rd(tfd_pkg::ADR_COUNT);
        chk(rd_v, 32'hFFFF);
        chk({31'h0, dout}, 32'h0);
        wr(tfd_pkg::ADR_ENABLE, 32'h1);
        for (int i = 0; i < 9; i++)
        begin
            seed = xs(seed);
            esel = 2'(i % 3);
            r = i < 3 ? 0 : int'(seed[2:0]);
            sel = seed[8];
            wr(tfd_pkg::ADR_MODE, {24'h0, esel, 5'h0, sel});
            wr(tfd_pkg::ADR_RELOAD, 32'(r));
            wr(tfd_pkg::ADR_CLEAR, 32'h1);
            cnt_on <= 1'b1;
            wr(tfd_pkg::ADR_START, 32'h1);
            half <= 4'h6 + {2'h0, seed[5:4]};
            run <= 1'b1;
            repeat (60 + int'(seed[12:9]) * 8) @(posedge core_clk);
            run <= 1'b0;
            repeat (8) @(posedge core_clk);
            chk(32'(tog), 32'(exp_tog(edges, r, sel)));
            rd(tfd_pkg::ADR_COUNT);
            chk(rd_v, 32'(r - (edges - 1) % (r + 1)));
            chk({31'h0, irq}, 32'(tog > 0));
            wr(tfd_pkg::ADR_CLEAR, 32'h1);
            rd(tfd_pkg::ADR_STATUS);
            chk(rd_v, 32'h0);
            cnt_on <= 1'b0;
            @(posedge core_clk);
        end
        // reload rewritten mid-count only applies at the next load
        esel = tfd_pkg::EDGE_RISE;
        wr(tfd_pkg::ADR_MODE, 32'h0000_0040);
        wr(tfd_pkg::ADR_RELOAD, 32'h0000_0005);
        cnt_on <= 1'b1;
        wr(tfd_pkg::ADR_START, 32'h0000_0001);
        run <= 1'b1;
        repeat (30) @(posedge core_clk);
        run <= 1'b0;
        repeat (8) @(posedge core_clk);
        e1 = edges;
        r = 5 - (e1 - 1) % 6;
        t1 = (e1 - 1) / 6;
        wr(tfd_pkg::ADR_RELOAD, 32'h0000_0002);
        run <= 1'b1;
        repeat (120) @(posedge core_clk);
        run <= 1'b0;
        repeat (8) @(posedge core_clk);
        e1 = edges - e1;
        rd(tfd_pkg::ADR_COUNT);
        chk(rd_v, 32'(e1 <= r ? r - e1 : 2 - (e1 - r - 1) % 3));
        chk(32'(tog), 32'(e1 <= r ? t1 : t1 + 1 + (e1 - r - 1) / 3));
        cnt_on <= 1'b0;
        @(posedge core_clk);
        wr(tfd_pkg::ADR_ENABLE, 32'h0);
        end_of_test();
    end
endmodule : tfd_divider_tb
`default_nettype wire
